// *** verilog/sfdp_sector_map_rom.sv ***
// axi4-lite slave exposing the read-only sector map parameter bytes
`timescale 1ns/1ps
module sfdp_sector_map_rom (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] detect_byte,
  output logic uniform_256k
);
  // write path: address and data may come in either order
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [7:0] select_q;
  logic [7:0] detect_meta_q;
  logic [7:0] detect_sync_q;
  logic u256_w;
  logic [7:0] byte_w [4];
  logic hit_w [4];
  logic [7:0] rd_off;
  logic [3:0] wstrb_q;
  logic lanes_hit;

  function automatic logic rom_space(input logic [7:0] addr);
    rom_space = addr < smap_pkg::axi_status;
  endfunction : rom_space

  // readies are flops so no port leaves through gates
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (aw_held_q && w_held_q) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (aw_held_q && w_held_q) begin
      w_held_q <= 1'b0;
    end
  end

  // writes to the parameter area are answered but never stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= smap_pkg::resp_okay;
      select_q <= 8'h00;
    end else if (aw_held_q && w_held_q) begin
      s_axi_bvalid <= 1'b1;
      if (awaddr_q == smap_pkg::axi_select) begin
        s_axi_bresp <= smap_pkg::resp_okay;
        if (wstrb_q[0]) begin
          select_q <= wdata_q[7:0];
        end
      end else if (rom_space(awaddr_q)) begin
        s_axi_bresp <= smap_pkg::resp_slverr;
      end else begin
        s_axi_bresp <= smap_pkg::resp_slverr;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // detection byte arrives from the register file domain, two flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      detect_meta_q <= 8'h00;
      detect_sync_q <= 8'h00;
    end else begin
      detect_meta_q <= detect_byte;
      detect_sync_q <= detect_meta_q;
    end
  end

  smap_sizesel u_sel (
    .detect_byte(detect_sync_q),
    .uniform_256k(u256_w)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      uniform_256k <= 1'b0;
    end else begin
      uniform_256k <= u256_w;
    end
  end

  // read path: one word, four byte lookups
  assign rd_off = smap_pkg::base_offset + {s_axi_araddr[4:2], 2'b00};

  for (genvar i = 0; i < 4; i++) begin : g_lane
    smap_rom u_rom (
      .offset(rd_off + 8'(i)),
      .data(byte_w[i]),
      .hit(hit_w[i])
    );
  end

  assign lanes_hit = hit_w[0] && hit_w[1] && hit_w[2] && hit_w[3];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= smap_pkg::resp_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= smap_pkg::resp_okay;
      if (rom_space(s_axi_araddr) && lanes_hit) begin
        s_axi_rdata <= {byte_w[3], byte_w[2], byte_w[1], byte_w[0]};
      end else if (s_axi_araddr == smap_pkg::axi_status) begin
        s_axi_rdata <= {24'h00_0000, 7'h00, uniform_256k};
      end else if (s_axi_araddr == smap_pkg::axi_select) begin
        s_axi_rdata <= {24'h00_0000, select_q};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= smap_pkg::resp_slverr;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_word_one: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00
    |=> s_axi_rdata == 32'h0000_0002)
    else $error("word at 54h wrong");

  a_mask_byte: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h04
    |=> s_axi_rdata[31:24] == 8'h02)
    else $error("mask byte wrong");

  a_size_sel: assert property (
    detect_sync_q[1]
    |-> ##2 uniform_256k || !$past(detect_sync_q[1]))
    else $error("size select wrong");

  a_size_follow: assert property (
    aresetn && $past(aresetn)
    |-> uniform_256k == $past(detect_sync_q[1]))
    else $error("size select lags wrong");

  a_status_read: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h20
    |=> s_axi_rdata == {31'h0000_0000, $past(uniform_256k)})
    else $error("status bit wrong");

  a_addr_len: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h04
    |=> s_axi_rdata[23:16] == 8'hff)
    else $error("len latency bits wrong");

  a_len_field: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h04
    |=> s_axi_rdata[23:22] == 2'h3)
    else $error("address length field wrong");

  a_latency: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h04
    |=> s_axi_rdata[19:16] == 4'hf)
    else $error("latency wrong");

  a_rfu_pair: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h04
    |=> s_axi_rdata[21:20] == 2'h3)
    else $error("reserved pair wrong");

  a_opcode: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h04
    |=> s_axi_rdata[15:0] == 16'h65fd)
    else $error("opcode or low byte wrong");

  a_opcode_byte: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h04
    |=> s_axi_rdata[15:8] == 8'h65)
    else $error("opcode byte wrong");

  a_low_detect3: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h04
    |=> s_axi_rdata[7:0] == 8'hfd)
    else $error("detect3 low byte wrong");

  a_word_three: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h08
    |=> s_axi_rdata == 32'h0000_0004)
    else $error("word at 5Ch wrong");

  a_header: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h0c
    |=> s_axi_rdata == 32'hff02_00fe)
    else $error("header wrong");

  a_hdr_top: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h0c
    |=> s_axi_rdata[31:24] == 8'hff)
    else $error("header top byte wrong");

  a_region_cnt: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h0c
    |=> s_axi_rdata[23:16] == 8'h02)
    else $error("region count wrong");

  a_config_id: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h0c
    |=> s_axi_rdata[15:8] == 8'h00)
    else $error("configuration id wrong");

  a_hdr_low: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h0c
    |=> s_axi_rdata[7:0] == 8'hfe)
    else $error("header low byte wrong");

  a_region0: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h10
    |=> s_axi_rdata == 32'h0000_7ff1)
    else $error("region 0 wrong");

  a_region_size: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h10
    |=> s_axi_rdata[31:8] == 24'h00_007f)
    else $error("region size wrong");

  a_erase_types: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h10
    |=> s_axi_rdata[7:0] == 8'hf1)
    else $error("erase type byte wrong");

  a_rom_write: assert property (
    aw_held_q && w_held_q && awaddr_q < 8'h20
    |=> s_axi_bvalid && s_axi_bresp == 2'h2)
    else $error("rom write accepted");

  a_rom_keep: assert property (
    aw_held_q && w_held_q && awaddr_q != 8'h24
    |=> $stable(select_q))
    else $error("write outside select stored");

  a_rom_okay: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr <= 8'h10
    |=> s_axi_rresp == 2'h0)
    else $error("rom read refused");

  a_gap_err: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h14 && s_axi_araddr <= 8'h1c
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read answered");

  a_select_write: assert property (
    aw_held_q && w_held_q && awaddr_q == 8'h24
    |=> s_axi_bvalid && s_axi_bresp == 2'h0)
    else $error("select write refused");

  a_ar_refused: assert property (
    s_axi_rvalid
    |-> !s_axi_arready)
    else $error("read taken while answer pending");

  a_aw_refused: assert property (
    s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");

  a_write_hold: assert property (
    s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");

  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid)
    else $error("read answer missing");

  a_read_hold: assert property (
    s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");

  c_rom_read: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == 2'h0);
  c_gap_read: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  c_write_err: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_select_wr: cover property (s_axi_bvalid && s_axi_bresp == 2'h0);
  c_u256: cover property (uniform_256k);
endmodule : sfdp_sector_map_rom

// *** verilog/smap_pkg.sv ***
// constants for the sector map parameter storage
package smap_pkg;
  localparam logic [7:0] base_offset = 8'h54;
  localparam logic [7:0] last_offset = 8'h67;
  localparam int rom_bytes = 20;
  localparam logic [31:0] detect2_addr = 32'h0000_0002;
  localparam logic [7:0] mask_bit1 = 8'h02;
  localparam logic [1:0] addr_len_var = 2'h3;
  localparam logic [1:0] rfu_pair = 2'h3;
  localparam logic [3:0] latency_var = 4'hf;
  localparam logic [7:0] read_any_reg_op = 8'h65;
  localparam logic [7:0] detect3_low = 8'hfd;
  localparam logic [31:0] detect3_addr = 32'h0000_0004;
  localparam logic [7:0] hdr_rfu = 8'hff;
  localparam logic [7:0] region_count_m1 = 8'h02;
  localparam logic [7:0] config_id0 = 8'h00;
  localparam logic [7:0] hdr_low = 8'hfe;
  localparam logic [23:0] region0_size = 24'h00_007f;
  localparam logic [7:0] region0_low = 8'hf1;
  localparam logic [31:0] detect3_word = {mask_bit1, addr_len_var, rfu_pair, latency_var,
                                         read_any_reg_op, detect3_low};
  localparam logic [31:0] hdr_word = {hdr_rfu, region_count_m1, config_id0, hdr_low};
  localparam logic [31:0] region0_word = {region0_size, region0_low};
  // axi-lite map: word n holds parameter offsets base+4n..base+4n+3
  localparam logic [7:0] axi_rom_base = 8'h00;
  localparam logic [7:0] axi_status = 8'h20;
  localparam logic [7:0] axi_select = 8'h24;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage : smap_pkg

// *** verilog/smap_rom.sv ***
// byte lookup of the sector map parameter bytes
`timescale 1ns/1ps
module smap_rom (
  input wire logic [7:0] offset,
  output logic [7:0] data,
  output logic hit
);
  function automatic logic [7:0] pick(input logic [31:0] w, input logic [1:0] b);
    pick = w[b*8 +: 8];
  endfunction : pick

  logic [7:0] rel;
  assign rel = offset - smap_pkg::base_offset;
  assign hit = (offset >= smap_pkg::base_offset) && (offset <= smap_pkg::last_offset);

  always_comb begin
    data = 8'h00;
    if (!hit) begin
      data = 8'h00;
    end else if (rel[4:2] == 3'd0) begin
      data = pick(smap_pkg::detect2_addr, rel[1:0]);
    end else if (rel[4:2] == 3'd1) begin
      data = pick(smap_pkg::detect3_word, rel[1:0]);
    end else if (rel[4:2] == 3'd2) begin
      data = pick(smap_pkg::detect3_addr, rel[1:0]);
    end else if (rel[4:2] == 3'd3) begin
      data = pick(smap_pkg::hdr_word, rel[1:0]);
    end else begin
      data = pick(smap_pkg::region0_word, rel[1:0]);
    end
  end
endmodule : smap_rom

// *** verilog/smap_sizesel.sv ***
// sector map choice from detection byte
`timescale 1ns/1ps
module smap_sizesel (
  input wire logic [7:0] detect_byte,
  output logic uniform_256k
);
  // only the masked bit counts; other bits are don't-care
  assign uniform_256k = |(detect_byte & smap_pkg::mask_bit1);
endmodule : smap_sizesel

// *** dv/host_detect.sv ***
// host side: hands over the detection byte and picks its sector map
`timescale 1ns/1ps
module host_detect (
  input wire logic aclk,
  input wire logic [7:0] value,
  output logic [7:0] detect_byte,
  output logic picks_256k
);
  // byte changes only after an edge, as the read answer would
  always_ff @(posedge aclk) begin
    detect_byte <= value;
  end
  // only the masked bit counts, the rest is ignored
  assign picks_256k = (detect_byte & smap_pkg::mask_bit1) != 8'h00;
endmodule : host_detect

// *** dv/tb.sv ***
// bench for the sector map parameter storage
`timescale 1ns/1ps
module tb;
  logic aclk = 0, aresetn = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, value = 0, detect_byte;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, uniform_256k, picks_256k;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] exp_w [5];
  int fails = 0, tests_run = 0;
  always #10 aclk = ~aclk;
  sfdp_sector_map_rom sfdp_sector_map_rom_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .detect_byte, .uniform_256k);
  host_detect host_detect_i (.aclk, .value, .detect_byte, .picks_256k);
  task automatic give_verdict();
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // flags sampled at the falling edge, so the handshake edge is the next rising one
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ta, tw, tb_;
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_awvalid <= 1; s_axi_wdata <= v; s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (n < 50) begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready; tw = s_axi_wvalid & s_axi_wready;
      tb_ = s_axi_bvalid & s_axi_bready; rs = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      if (tb_) begin
        s_axi_bready <= 0;
        n = 100;
      end
      n++;
    end
    if (n < 100) begin
      fails++;
      give_verdict();
    end
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ta, tr;
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    while (n < 50) begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready; tr = s_axi_rvalid & s_axi_rready;
      v = s_axi_rdata; rs = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 0;
      if (tr) begin
        s_axi_rready <= 0;
        n = 100;
      end
      n++;
    end
    if (n < 100) begin
      fails++;
      give_verdict();
    end
  endtask : axr
  initial begin
    exp_w[0] = 32'h0000_0002;
    exp_w[1] = 32'h02ff_65fd;
    exp_w[2] = 32'h0000_0004;
    exp_w[3] = 32'hff02_00fe;
    exp_w[4] = 32'h0000_7ff1;
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    for (int i = 0; i < 5; i++) begin
      axr(8'(4 * i), d, r);
      chk("rom word", exp_w[i], d);
      chk("rom resp", {30'h0, smap_pkg::resp_okay}, {30'h0, r});
    end
    axr(8'h04, d, r);
    chk("mask byte", 32'h0000_0002, {24'h00_0000, d[31:24]});
    chk("addr len", 32'h0000_0003, {30'h0000_0000, d[23:22]});
    chk("latency rfu", 32'h0000_003f, {26'h000_0000, d[21:16]});
    chk("opcode", 32'h0000_0065, {24'h00_0000, d[15:8]});
    chk("detect3 low", 32'h0000_00fd, {24'h00_0000, d[7:0]});
    axr(8'h0c, d, r);
    chk("config id", 32'h0000_0000, {24'h00_0000, d[15:8]});
    chk("header low", 32'h0000_00fe, {24'h00_0000, d[7:0]});
    axr(8'h10, d, r);
    chk("erase types", 32'h0000_00f1, {24'h00_0000, d[7:0]});
    // writes into the table are refused and leave it intact
    for (int i = 0; i < 5; i++) begin
      axw(8'(4 * i), 32'hffff_ffff, r);
      chk("rom write resp", {30'h0, smap_pkg::resp_slverr}, {30'h0, r});
      axr(8'(4 * i), d, r);
      chk("rom after write", exp_w[i], d);
    end
    axr(8'h14, d, r);
    chk("unmapped data", 32'h0000_0000, d);
    chk("unmapped resp", {30'h0, smap_pkg::resp_slverr}, {30'h0, r});
    axw(8'h24, 32'h0000_00a5, r);
    chk("select write resp", {30'h0, smap_pkg::resp_okay}, {30'h0, r});
    axr(8'h24, d, r);
    chk("select", 32'h0000_00a5, d);
    axw(8'h20, 32'h0000_0001, r);
    chk("status write resp", {30'h0, smap_pkg::resp_slverr}, {30'h0, r});
    // other bits set but the masked one clear must still mean 64KB
    foreach (exp_w[i]) begin
      value <= (i % 2 == 1) ? 8'h02 : 8'hfd;
      repeat (5) @(posedge aclk);
      chk("map select", {31'h0, picks_256k}, {31'h0, uniform_256k});
      chk("map expect", {31'h0, i % 2 == 1}, {31'h0, uniform_256k});
      axr(8'h20, d, r);
      chk("status bit", {31'h0, i % 2 == 1}, {31'h0, d[0]});
    end
    give_verdict();
  end
endmodule : tb
